// file: inc/pls_pkg.sv
`default_nettype none
package pls_pkg;
    // serial frame layout
    localparam int          FRAME_BITS    = 24;
    localparam int          HDR_BITS      = 16;
    localparam int          ADDR_W        = 13;

    // register offsets
    localparam logic [12:0] ADDR_DET_CTRL = 13'h169;
    localparam logic [12:0] ADDR_CNT_HI   = 13'h16a;
    localparam logic [12:0] ADDR_CNT_LO   = 13'h16b;
    localparam logic [12:0] ADDR_PIN2_SEL = 13'h16e;
    localparam logic [12:0] ADDR_PWR      = 13'h173;
    localparam logic [12:0] ADDR_L1_HOLD  = 13'h177;
    localparam logic [12:0] ADDR_LOST_CLR = 13'h182;
    localparam logic [12:0] ADDR_LOCK_RB  = 13'h183;
    localparam logic [12:0] ADDR_INSEL_RB = 13'h184;
    localparam logic [12:0] ADDR_DAC_RB   = 13'h185;
    localparam logic [12:0] ADDR_HOLD_RB  = 13'h188;
    localparam logic [12:0] ADDR_WLOCK    = 13'h555;

    // reset values
    localparam logic [7:0]  RST_DET_CTRL  = 8'h58;
    localparam logic [7:0]  RST_CNT_HI    = 8'h00;
    localparam logic [7:0]  RST_CNT_LO    = 8'h00;
    localparam logic [7:0]  RST_PIN2_SEL  = 8'h06;
    localparam logic [7:0]  RST_PWR       = 8'h70;
    localparam logic [7:0]  RST_L1_HOLD   = 8'h00;
    localparam logic [7:0]  RST_LOST_CLR  = 8'h00;
    localparam logic [7:0]  RST_WLOCK     = 8'h00;
    localparam logic [9:0]  RST_DAC       = 10'h200;

    // writable bit masks, reserved bits read zero
    localparam logic [7:0]  MASK_DET_CTRL = 8'h7f;
    localparam logic [7:0]  MASK_CNT_HI   = 8'h3f;
    localparam logic [7:0]  MASK_PWR      = 8'h70;
    localparam logic [7:0]  MASK_L1_HOLD  = 8'h20;
    localparam logic [7:0]  MASK_LOST_CLR = 8'h03;

    // field positions
    localparam int          DET_WND_LSB   = 5;
    localparam int          DET_GAIN_LSB  = 3;
    localparam int          DET_POL_BIT   = 2;
    localparam int          DET_TRI_BIT   = 1;
    localparam int          DET_FORCE_BIT = 0;
    localparam int          PIN2_SRC_LSB  = 3;
    localparam int          PWR_PRE_BIT   = 6;
    localparam int          PWR_L2_BIT    = 5;
    localparam int          PWR_FIN_BIT   = 4;
    localparam int          L1_HOLD_BIT   = 5;
    localparam int          CLR1_BIT      = 1;
    localparam int          CLR2_BIT      = 0;
    localparam int          HOLD_RB_BIT   = 4;

    // lock window widths in picoseconds
    localparam logic [11:0] WIN1_PS       = 12'd1000;
    localparam logic [11:0] WIN2_PS       = 12'd1800;
    localparam logic [11:0] WIN3_PS       = 12'd2600;

    typedef enum logic [4:0] {
        SRC_LOW     = 5'h00,
        SRC_L1_LOCK = 5'h01,
        SRC_L2_LOCK = 5'h02,
        SRC_BOTH    = 5'h03,
        SRC_HOLD    = 5'h04,
        SRC_DAC_LK  = 5'h05,
        SRC_READ    = 5'h07,
        SRC_RAIL    = 5'h08,
        SRC_DAC_LO  = 5'h09,
        SRC_DAC_HI  = 5'h0a,
        SRC_L1N     = 5'h0b,
        SRC_L1N_H   = 5'h0c,
        SRC_L2N     = 5'h0d,
        SRC_L2N_H   = 5'h0e,
        SRC_L1R     = 5'h0f,
        SRC_L1R_H   = 5'h10,
        SRC_L2R     = 5'h11,
        SRC_L2R_H   = 5'h12
    } pls_src_t;

    typedef enum logic [2:0] {
        PT_PUSH = 3'h3,
        PT_INV  = 3'h4,
        PT_OD   = 3'h6
    } pls_pin_type_t;
endpackage : pls_pkg
`default_nettype wire

// file: design/pls_serial_port.sv
`timescale 1ns/10ps
`default_nettype none
module pls_serial_port
    import pls_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        spiSelN,
    input  wire logic        spiClk,
    input  wire logic        spiDataIn,
    output logic             spiDataOut,
    output logic             spiDriveN,
    output logic             regWrStrobe,
    output logic [12:0]      regAddr,
    output logic [7:0]       regWrData,
    input  wire logic [7:0]  regRdData
);
    logic        sckPrev;
    logic [4:0]  bitCnt;
    logic [23:0] shiftIn;
    logic [7:0]  rdShift;
    logic        isRead;
    logic        addrPend;
    logic        loadPend;
    logic        wrPend;
    logic        sckRise;
    logic        sckFall;

    assign sckRise    = spiClk & ~sckPrev;
    assign sckFall    = ~spiClk & sckPrev;
    assign spiDataOut = rdShift[7];

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sckPrev <= 1'b0;
        end else begin
            sckPrev <= spiClk;
        end
    end

    // bit capture, msb first
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            bitCnt   <= 5'h00;
            shiftIn  <= 24'h000000;
            addrPend <= 1'b0;
            wrPend   <= 1'b0;
        end else begin
            addrPend <= !spiSelN && sckRise && bitCnt == 5'(HDR_BITS - 1);
            wrPend   <= !spiSelN && sckRise && bitCnt == 5'(FRAME_BITS - 1) && !isRead;
            if (spiSelN) begin
                bitCnt <= 5'h00;
            end else if (sckRise && bitCnt < 5'(FRAME_BITS)) begin
                shiftIn <= {shiftIn[22:0], spiDataIn};
                bitCnt  <= 5'(bitCnt + 5'h01);
            end
        end
    end

    // header decode and write strobe
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            regAddr     <= 13'h0000;
            isRead      <= 1'b0;
            loadPend    <= 1'b0;
            regWrStrobe <= 1'b0;
            regWrData   <= 8'h00;
        end else begin
            loadPend    <= addrPend & shiftIn[15];
            regWrStrobe <= wrPend & ~spiSelN;
            if (addrPend) begin
                regAddr <= shiftIn[12:0];
                isRead  <= shiftIn[15];
            end
            if (wrPend) begin
                regWrData <= shiftIn[7:0];
            end
        end
    end

    // read data shifted out on falling edges
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdShift   <= 8'h00;
            spiDriveN <= 1'b1;
        end else if (spiSelN) begin
            rdShift   <= 8'h00;
            spiDriveN <= 1'b1;
        end else if (loadPend) begin
            rdShift   <= regRdData;
            spiDriveN <= 1'b0;
        end else if (sckFall && isRead && bitCnt > 5'(HDR_BITS)
                     && bitCnt < 5'(FRAME_BITS)) begin
            rdShift <= {rdShift[6:0], 1'b0};
        end
    end
endmodule : pls_serial_port
`default_nettype wire

// file: design/pls_lock_status.sv
// Contract
// - window code 1/2/3 selects 1 ns, 1.8 ns, 2.6 ns; code 0 reserved
// - loop2 lock only after programmed nonzero count of in-window cycles
// - pump gain code 2 is 1600 uA, 3 is 3200 uA; 0,1 reserved
// - polarity 0 negative slope, 1 positive slope; resets to 0
// - pump disable 1 puts pump output in high impedance
// - lock detect runs only when routed out, or always when forced
// - status pin2 drives one source per selector code
// - pin2 type 3 push-pull, 4 inverted, 6 open drain; resets to 6
// - three power-down bits, 1 powers down, all reset to 1
// - loop1 divider hold bit holds divider, loop1 never locks
// - lost flag cleared by writing 1 then 0; held 0 while 1
// - lost flag sets on falling lock edge only
// - lock readback bits show current lock levels
// - 0x184 holds input selects 5:3, signal loss 1:0, dac top bits
// - dac readback is 512 after reset, may change after loop1 locks
// - holdover readback bit 4 is 1 in holdover
// - nonzero write lock blocks writes except to 0x555
// - write lock register reads back as zero
// - out-of-window edge returns lock counter to zero
`timescale 1ns/10ps
`default_nettype none
module pls_lock_status
    import pls_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic        spiSelN,
    input  wire logic        spiClk,
    input  wire logic        spiDataIn,
    output logic             spiDataOut,
    output logic             spiDriveN,
    input  wire logic        loop1LockRaw,
    input  wire logic        loop2PdCycle,
    input  wire logic [11:0] loop2EdgeErrPs,
    input  wire logic [4:0]  statusPin1Source,
    input  wire logic        holdoverActive,
    input  wire logic        dacLocked,
    input  wire logic        dacRail,
    input  wire logic        dacLow,
    input  wire logic        dacHigh,
    input  wire logic [3:0]  dividerOut,
    input  wire logic [2:0]  refInputSelected,
    input  wire logic [1:0]  refInputSignalLoss,
    input  wire logic [9:0]  dacValueIn,
    output logic [1:0]       loop2WindowSize,
    output logic [1:0]       loop2PumpGain,
    output logic             loop2PumpPolarity,
    output logic             loop2PumpDisable,
    output logic             prescalerPowerDown,
    output logic             loop2PowerDown,
    output logic             feedbackInputPowerDown,
    output logic             loop1RefDividerHold,
    output logic             loop1Lock,
    output logic             loop2Lock,
    output logic             statusPin2,
    output logic             statusPin2DriveN
);
    logic [7:0]  detCtrl;
    logic [7:0]  cntHi;
    logic [7:0]  cntLo;
    logic [7:0]  pin2Sel;
    logic [7:0]  pwrCtrl;
    logic [7:0]  l1Hold;
    logic [7:0]  lostClr;
    logic [7:0]  writeLock;
    logic [9:0]  dacValue;
    logic        dacSeen;
    logic        regWrStrobe;
    logic [12:0] regAddr;
    logic [7:0]  regWrData;
    logic [7:0]  regRdData;
    logic        wrOk;
    logic [13:0] lockTarget;
    logic [13:0] lockCount;
    logic [13:0] next_lockCount;
    logic        detectRun;
    logic        inWindow;
    logic        loop1LockPrev;
    logic        loop2LockPrev;
    logic        loop1LostFlag;
    logic        loop2LostFlag;
    logic [3:0]  divPrev;
    logic [3:0]  divHalf;
    logic        pin2Value;
    logic [4:0]  pin2Source;
    logic [2:0]  pin2Type;

    function automatic logic uses_loop2(input logic [4:0] src);
        return src == SRC_L2_LOCK || src == SRC_BOTH;
    endfunction : uses_loop2

    function automatic logic [11:0] window_limit_ps(input logic [1:0] code);
        case (code)
            2'h1:    return WIN1_PS;
            2'h2:    return WIN2_PS;
            2'h3:    return WIN3_PS;
            default: return 12'h000;
        endcase
    endfunction : window_limit_ps

    pls_serial_port u_port (
        .core_clk    (core_clk),
        .rst_n       (rst_n),
        .spiSelN     (spiSelN),
        .spiClk      (spiClk),
        .spiDataIn   (spiDataIn),
        .spiDataOut  (spiDataOut),
        .spiDriveN   (spiDriveN),
        .regWrStrobe (regWrStrobe),
        .regAddr     (regAddr),
        .regWrData   (regWrData),
        .regRdData   (regRdData)
    );

    // configuration fields
    assign loop2WindowSize        = detCtrl[DET_WND_LSB +: 2];
    assign loop2PumpGain          = detCtrl[DET_GAIN_LSB +: 2];
    assign loop2PumpPolarity      = detCtrl[DET_POL_BIT];
    assign loop2PumpDisable       = detCtrl[DET_TRI_BIT];
    assign prescalerPowerDown     = pwrCtrl[PWR_PRE_BIT];
    assign loop2PowerDown         = pwrCtrl[PWR_L2_BIT];
    assign feedbackInputPowerDown = pwrCtrl[PWR_FIN_BIT];
    assign loop1RefDividerHold    = l1Hold[L1_HOLD_BIT];
    assign pin2Source             = pin2Sel[PIN2_SRC_LSB +: 5];
    assign pin2Type               = pin2Sel[2:0];
    assign lockTarget             = {cntHi[5:0], cntLo};

    assign wrOk = regWrStrobe && (writeLock == 8'h00 || regAddr == ADDR_WLOCK);

    // register writes; blocked writes leave every register untouched
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            detCtrl   <= RST_DET_CTRL;
            cntHi     <= RST_CNT_HI;
            cntLo     <= RST_CNT_LO;
            pin2Sel   <= RST_PIN2_SEL;
            pwrCtrl   <= RST_PWR;
            l1Hold    <= RST_L1_HOLD;
            lostClr   <= RST_LOST_CLR;
            writeLock <= RST_WLOCK;
        end else if (wrOk) begin
            if (regAddr == ADDR_DET_CTRL) begin
                detCtrl <= regWrData & MASK_DET_CTRL;
            end else if (regAddr == ADDR_CNT_HI) begin
                cntHi <= regWrData & MASK_CNT_HI;
            end else if (regAddr == ADDR_CNT_LO) begin
                cntLo <= regWrData;
            end else if (regAddr == ADDR_PIN2_SEL) begin
                pin2Sel <= regWrData;
            end else if (regAddr == ADDR_PWR) begin
                pwrCtrl <= regWrData & MASK_PWR;
            end else if (regAddr == ADDR_L1_HOLD) begin
                l1Hold <= regWrData & MASK_L1_HOLD;
            end else if (regAddr == ADDR_LOST_CLR) begin
                lostClr <= regWrData & MASK_LOST_CLR;
            end else if (regAddr == ADDR_WLOCK) begin
                writeLock <= regWrData;
            end
        end
    end

    // read mux
    always_comb begin
        if (regAddr == ADDR_DET_CTRL) begin
            regRdData = detCtrl;
        end else if (regAddr == ADDR_CNT_HI) begin
            regRdData = cntHi;
        end else if (regAddr == ADDR_CNT_LO) begin
            regRdData = cntLo;
        end else if (regAddr == ADDR_PIN2_SEL) begin
            regRdData = pin2Sel;
        end else if (regAddr == ADDR_PWR) begin
            regRdData = pwrCtrl;
        end else if (regAddr == ADDR_L1_HOLD) begin
            regRdData = l1Hold;
        end else if (regAddr == ADDR_LOST_CLR) begin
            regRdData = lostClr;
        end else if (regAddr == ADDR_LOCK_RB) begin
            regRdData = {4'h0, loop1LostFlag, loop1Lock, loop2LostFlag, loop2Lock};
        end else if (regAddr == ADDR_INSEL_RB) begin
            regRdData = {dacValue[9:8], refInputSelected, 1'b0, refInputSignalLoss};
        end else if (regAddr == ADDR_DAC_RB) begin
            regRdData = dacValue[7:0];
        end else if (regAddr == ADDR_HOLD_RB) begin
            regRdData = 8'(holdoverActive) << HOLD_RB_BIT;
        end else begin
            regRdData = 8'h00;
        end
    end

    // loop2 lock detector
    assign detectRun = detCtrl[DET_FORCE_BIT] || uses_loop2(pin2Source)
                       || uses_loop2(statusPin1Source);
    assign inWindow  = loop2WindowSize != 2'h0
                       && loop2EdgeErrPs <= window_limit_ps(loop2WindowSize);

    always_comb begin
        next_lockCount = lockCount;
        if (!detectRun || lockTarget == 14'h0000) begin
            next_lockCount = 14'h0000;
        end else if (loop2PdCycle) begin
            if (!inWindow) begin
                next_lockCount = 14'h0000;
            end else if (lockCount >= lockTarget) begin
                next_lockCount = lockTarget;
            end else begin
                next_lockCount = 14'(lockCount + 14'h0001);
            end
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            lockCount <= 14'h0000;
            loop2Lock <= 1'b0;
        end else begin
            lockCount <= next_lockCount;
            loop2Lock <= detectRun && lockTarget != 14'h0000
                         && next_lockCount == lockTarget;
        end
    end

    // loop1 lock gated by divider hold
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loop1Lock <= 1'b0;
        end else begin
            loop1Lock <= loop1LockRaw & ~loop1RefDividerHold;
        end
    end

    // sticky lock-lost flags
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            loop1LockPrev <= 1'b0;
            loop2LockPrev <= 1'b0;
            loop1LostFlag <= 1'b0;
            loop2LostFlag <= 1'b0;
        end else begin
            loop1LockPrev <= loop1Lock;
            loop2LockPrev <= loop2Lock;
            if (lostClr[CLR1_BIT]) begin
                loop1LostFlag <= 1'b0;
            end else if (loop1LockPrev && !loop1Lock) begin
                loop1LostFlag <= 1'b1;
            end
            if (lostClr[CLR2_BIT]) begin
                loop2LostFlag <= 1'b0;
            end else if (loop2LockPrev && !loop2Lock) begin
                loop2LostFlag <= 1'b1;
            end
        end
    end

    // dac readback follows the loop only after first loop1 lock
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            dacSeen  <= 1'b0;
            dacValue <= RST_DAC;
        end else begin
            if (loop1Lock) begin
                dacSeen <= 1'b1;
            end
            if (dacSeen) begin
                dacValue <= dacValueIn;
            end
        end
    end

    // divider half-rate toggles
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            divPrev <= 4'h0;
            divHalf <= 4'h0;
        end else begin
            divPrev <= dividerOut;
            divHalf <= divHalf ^ (dividerOut & ~divPrev);
        end
    end

    // status pin2 source select
    always_comb begin
        case (pin2Source)
            SRC_L1_LOCK: pin2Value = loop1Lock;
            SRC_L2_LOCK: pin2Value = loop2Lock;
            SRC_BOTH:    pin2Value = loop1Lock & loop2Lock;
            SRC_HOLD:    pin2Value = holdoverActive;
            SRC_DAC_LK:  pin2Value = dacLocked;
            SRC_READ:    pin2Value = spiDataOut;
            SRC_RAIL:    pin2Value = dacRail;
            SRC_DAC_LO:  pin2Value = dacLow;
            SRC_DAC_HI:  pin2Value = dacHigh;
            SRC_L1N:     pin2Value = dividerOut[0];
            SRC_L1N_H:   pin2Value = divHalf[0];
            SRC_L2N:     pin2Value = dividerOut[1];
            SRC_L2N_H:   pin2Value = divHalf[1];
            SRC_L1R:     pin2Value = dividerOut[2];
            SRC_L1R_H:   pin2Value = divHalf[2];
            SRC_L2R:     pin2Value = dividerOut[3];
            SRC_L2R_H:   pin2Value = divHalf[3];
            default:     pin2Value = 1'b0;
        endcase
    end

    // status pin2 output type
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            statusPin2       <= 1'b0;
            statusPin2DriveN <= 1'b1;
        end else begin
            case (pin2Type)
                PT_PUSH: begin
                    statusPin2       <= pin2Value;
                    statusPin2DriveN <= 1'b0;
                end
                PT_INV: begin
                    statusPin2       <= ~pin2Value;
                    statusPin2DriveN <= 1'b0;
                end
                PT_OD: begin
                    statusPin2       <= 1'b0;
                    statusPin2DriveN <= pin2Value;
                end
                default: begin
                    statusPin2       <= 1'b0;
                    statusPin2DriveN <= 1'b1;
                end
            endcase
        end
    end

    // checks
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    a_lost_held_clear: assert property (lostClr[CLR1_BIT] |=> !loop1LostFlag)
        else $error("loop1 lost flag set while clear held");
    a_lost_on_fall: assert property (loop2LockPrev && !loop2Lock && !lostClr[CLR2_BIT]
        |=> loop2LostFlag)
        else $error("loop2 lost flag missed falling lock");
    a_lock_needs_count: assert property (loop2Lock |-> lockCount == $past(lockTarget)
        && lockTarget != 14'h0000)
        else $error("loop2 lock without full count");
    a_count_out_window: assert property (loop2PdCycle && !inWindow
        |=> lockCount == 14'h0000 && !loop2Lock)
        else $error("lock counter not cleared out of window");
    a_write_lock_blocks: assert property (regWrStrobe && writeLock != 8'h00
        && regAddr != ADDR_WLOCK |=> $stable(detCtrl) && $stable(pin2Sel)
        && $stable(lostClr) && $stable(pwrCtrl))
        else $error("locked register changed on write");
    a_hold_no_lock: assert property ($past(loop1RefDividerHold) |-> !loop1Lock)
        else $error("loop1 reports lock while divider held");
    a_detect_gated: assert property (!detectRun |=> lockCount == 14'h0000
        && !loop2Lock)
        else $error("lock detector ran while not routed");
    a_open_drain: assert property ($past(rst_n) && $past(pin2Type) == PT_OD |-> !statusPin2
        && statusPin2DriveN == $past(pin2Value))
        else $error("open drain pin drove high");

    c_loop2_locked:  cover property ($rose(loop2Lock));
    c_lost_set:      cover property ($rose(loop1LostFlag));
    c_locked_write:  cover property (regWrStrobe && writeLock != 8'h00);
    c_serial_read:   cover property ($fell(spiDriveN));
endmodule : pls_lock_status
`default_nettype wire

// file: dv/pls_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module pls_host_model (
    input  wire logic core_clk,
    input  wire logic spiDataOut,
    input  wire logic spiDriveN,
    output logic      spiSelN,
    output logic      spiClk,
    output logic      spiDataIn
);
    logic [23:0] frm;
    initial begin
        spiSelN = 1'b1;
        spiClk = 1'b0;
        spiDataIn = 1'b0;
    end
    task automatic half();
        repeat (8) @(negedge core_clk);
    endtask : half
    // one frame msb first, clock idles low outside frames
    task automatic xfer(input logic rd, input logic [12:0] a, input logic [7:0] d,
                        output logic [7:0] q);
        frm = {rd, 2'b00, a, d};
        spiSelN = 1'b0;
        for (int i = 23; i >= 0; i--) begin
            spiDataIn = (rd && i < 8) ? ~spiDataIn : frm[i];
            half();
            if (i < 8) q[i] = spiDriveN ? 1'bx : spiDataOut;
            spiClk = 1'b1;
            half();
            spiClk = 1'b0;
        end
        half();
        spiSelN = 1'b1;
        spiDataIn = ~spiDataIn;
        half();
    endtask : xfer
endmodule : pls_host_model
`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
module tb_top
    import pls_pkg::*;
;
    logic core_clk, rst_n, spiSelN, spiClk, spiDataIn, spiDataOut, spiDriveN;
    logic loop1LockRaw, loop2PdCycle, holdoverActive, dacLocked, dacRail, dacLow, dacHigh;
    logic loop2PumpPolarity, loop2PumpDisable, prescalerPowerDown, loop2PowerDown;
    logic feedbackInputPowerDown, loop1RefDividerHold, loop1Lock, loop2Lock;
    logic statusPin2, statusPin2DriveN;
    logic [1:0]  loop2WindowSize, loop2PumpGain, refInputSignalLoss;
    logic [2:0]  refInputSelected;
    logic [3:0]  dividerOut;
    logic [4:0]  statusPin1Source;
    logic [9:0]  dacValueIn;
    logic [11:0] loop2EdgeErrPs;
    logic [7:0]  mix, wlock;
    logic [31:0] seed = 32'h8ecf;
    logic [7:0]  mdl [int];
    logic [7:0]  msk [int];
    logic [12:0] rwA [6] = '{ADDR_DET_CTRL, ADDR_CNT_HI, ADDR_CNT_LO, ADDR_PIN2_SEL,
                             ADDR_PWR, ADDR_L1_HOLD};
    logic [7:0]  rwM [6] = '{8'h7f, 8'h3f, 8'hff, 8'hff, 8'h70, 8'h20};
    logic [7:0]  rwR [6] = '{RST_DET_CTRL, RST_CNT_HI, RST_CNT_LO, RST_PIN2_SEL,
                             RST_PWR, RST_L1_HOLD};
    logic [2:0]  ty [3] = '{3'h3, 3'h4, 3'h6};
    int          mismatches = 0;
    int          num_checks = 0;
    assign {dacRail, dacLow, dacHigh, dacLocked, dividerOut} = mix;
    pls_lock_status u_pls_lock_status (.*);
    pls_host_model u_host (.*);
    initial begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %s expected %h seen %h", n, exp, got);
        end
    endtask : chk
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        logic [7:0] q;
        u_host.xfer(1'b0, a, d, q);
        if (a == ADDR_WLOCK) wlock = d;
        else if (wlock == 8'h00 && mdl.exists(a)) mdl[a] = d & msk[a];
    endtask : wr
    task automatic rd(input logic [12:0] a, input logic [7:0] e);
        logic [7:0] q;
        u_host.xfer(1'b1, a, 8'h00, q);
        chk($sformatf("reg %h", a), q, e);
    endtask : rd
    task automatic pd(input logic [11:0] e);
        loop2EdgeErrPs = e;
        loop2PdCycle = 1'b1;
        @(negedge core_clk);
        loop2PdCycle = 1'b0;
        repeat (2) @(negedge core_clk);
    endtask : pd
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : summarize
    initial begin
        #(60000 * 5);
        mismatches++;
        summarize();
    end
    initial begin
        {rst_n, loop1LockRaw, loop2PdCycle, holdoverActive, loop2EdgeErrPs} = '0;
        statusPin1Source = '0;
        wlock = 8'h00;
        seed = lfsr(seed);
        {mix, refInputSelected, refInputSignalLoss, dacValueIn} = seed[22:0];
        foreach (rwA[i]) begin
            mdl[rwA[i]] = rwR[i];
            msk[rwA[i]] = rwM[i];
        end
        repeat (2) @(negedge core_clk);
        rst_n = 1'b1;
        chk("wnd", loop2WindowSize, 8'h02);
        chk("pol", loop2PumpPolarity, 8'h00);
        chk("pdn", {prescalerPowerDown, loop2PowerDown, feedbackInputPowerDown}, 8'h07);
        chk("drv", statusPin2DriveN, 8'h01);
        foreach (rwA[i]) rd(rwA[i], mdl[rwA[i]]);
        rd(ADDR_DAC_RB, 8'h00);
        rd(ADDR_INSEL_RB, {2'b10, refInputSelected, 1'b0, refInputSignalLoss});
        rd(ADDR_HOLD_RB, 8'h00);
        rd(13'h1f0, 8'h00);
        foreach (rwA[i]) begin
            seed = lfsr(seed);
            wr(rwA[i], seed[7:0] | (rwA[i] == ADDR_DET_CTRL ? 8'h30 : 8'h00));
            rd(rwA[i], mdl[rwA[i]]);
        end
        chk("ctl", {loop2WindowSize, loop2PumpGain, loop2PumpPolarity, loop2PumpDisable},
            {2'b00, mdl[ADDR_DET_CTRL][6:1]});
        chk("pwr", {prescalerPowerDown, loop2PowerDown, feedbackInputPowerDown},
            {5'h00, mdl[ADDR_PWR][6:4]});
        chk("hold", loop1RefDividerHold, {7'h00, mdl[ADDR_L1_HOLD][5]});
        wr(ADDR_WLOCK, seed[15:8] | 8'h01);
        wr(ADDR_DET_CTRL, ~mdl[ADDR_DET_CTRL]);
        rd(ADDR_DET_CTRL, mdl[ADDR_DET_CTRL]);
        rd(ADDR_WLOCK, 8'h00);
        wr(ADDR_WLOCK, 8'h00);
        wr(ADDR_PIN2_SEL, 8'h06);
        wr(ADDR_L1_HOLD, 8'h00);
        wr(ADDR_DET_CTRL, 8'h34);
        wr(ADDR_CNT_HI, 8'h00);
        wr(ADDR_CNT_LO, 8'h03);
        repeat (3) pd(12'd900);
        chk("run", loop2Lock, 8'h00);
        wr(ADDR_DET_CTRL, 8'h35);
        repeat (2) pd(12'd900);
        chk("lk2", loop2Lock, 8'h00);
        pd(12'd1000);
        chk("lk2", loop2Lock, 8'h01);
        rd(ADDR_LOCK_RB, 8'h01);
        pd(12'd1001);
        chk("lk2", loop2Lock, 8'h00);
        rd(ADDR_LOCK_RB, 8'h02);
        wr(ADDR_LOST_CLR, 8'h01);
        rd(ADDR_LOCK_RB, 8'h00);
        wr(ADDR_LOST_CLR, 8'h00);
        rd(ADDR_LOCK_RB, 8'h00);
        loop1LockRaw = 1'b1;
        rd(ADDR_LOCK_RB, 8'h04);
        rd(ADDR_DAC_RB, dacValueIn[7:0]);
        wr(ADDR_L1_HOLD, 8'h20);
        rd(ADDR_LOCK_RB, 8'h08);
        holdoverActive = 1'b1;
        rd(ADDR_HOLD_RB, 8'h10);
        foreach (ty[i]) begin
            wr(ADDR_PIN2_SEL, {5'h04, ty[i]});
            chk("pin", {statusPin2, statusPin2DriveN}, {ty[i] == 3'h3, ty[i] == 3'h6});
        end
        statusPin1Source = 5'h02;
        wr(ADDR_DET_CTRL, 8'h34);
        repeat (3) pd(12'd1000);
        chk("pin1", loop2Lock, 8'h01);
        summarize();
    end
endmodule : tb_top
`default_nettype wire
